//--- bench/stg_gate_top_tb.sv
// Register and decision tests for the port state gate
`timescale 1ns/1ns
module stg_gate_top_tb;
  import stg_pkg::*;
  logic        core_clk, rstn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, busy, sDyn, sSta, fDyn, fSta, rs, lkSrc, lkTag;
  logic        arvalid, arready, rvalid, rready, lkValid, lkOvr;
  logic [2:0]  lkMask, fMask;
  logic        fValid, fTail, lValid, lPort;
  logic [31:0] d;
  int          errCount, totalChecks;

  stg_gate_top i_stg_gate_top (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frameBusy(busy), .lkValid(lkValid),
    .lkSrc(lkSrc), .lkDstMask(lkMask), .lkStaticOvr(lkOvr),
    .lkHostTag(lkTag), .fwdValid(fValid), .fwdMask(fMask),
    .fwdTailSrc(fTail), .learnValid(lValid), .learnPort(lPort),
    .flushDyn(fDyn), .flushSta(fSta));

  stg_host_model i_stg_host_model (
    .core_clk(core_clk), .lkValid(lkValid), .lkSrc(lkSrc),
    .lkDstMask(lkMask), .lkStaticOvr(lkOvr), .lkHostTag(lkTag),
    .frameBusy(busy), .fwdValid(fValid), .fwdMask(fMask),
    .fwdTailSrc(fTail), .learnValid(lValid), .learnPort(lPort));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Flush pulses collected between clears
  always @(posedge core_clk) begin
    sDyn <= rstn ? (sDyn | fDyn) : 2'b00;
    sSta <= rstn ? (sSta | fSta) : 2'b00;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      errCount++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // Write with address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic aw, w;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!(bvalid === 1'b1 && !aw && !w) && n < 100);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 100) errCount++;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic ar;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar = 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 100) errCount++;
  endtask

  // Frame decision compared against expected mask and learning
  task automatic fr(input logic [1:0] s, input logic [2:0] m, input logic o,
                    input logic [1:0] t, input logic [4:0] e, input logic l);
    i_stg_host_model.send(s, m, o, t);
    chk("decision", {27'h0, e}, {27'h0, i_stg_host_model.got});
    chk("learn", {31'h0, l}, {31'h0, lValid});
  endtask

  initial begin
    errCount = 0;
    totalChecks = 0;
    rstn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {sDyn, sSta} = '0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd(ADR_P1CTRL); chk("p1ctrl", 32'h6, d);
    rd(ADR_P2CTRL); chk("p2ctrl", 32'h6, d);
    rd(ADR_GCTRL2); chk("gctrl2", 32'h0, d);
    rd(ADR_STATUS); chk("status", 32'h36, d);
    rd(8'hfc);
    chk("unmapped rd", {30'h0, RESP_SLVERR}, {d[29:0], rs});
    wr(8'hfc, 32'h1);
    chk("unmapped wr", RESP_SLVERR, rs);
    fr(SRC_P1, 3'h6, 1'b0, 2'h0, 5'h1c, 1'b1);
    chk("learn port", 32'h0, lPort);
    wr(ADR_P1CTRL, 32'h1); chk("wr resp", RESP_OKAY, rs);
    rd(ADR_STATUS); chk("status blk", 32'h31, d);
    fr(SRC_P1, 3'h6, 1'b0, 2'h0, 5'h10, 1'b0);
    fr(SRC_P1, 3'h6, 1'b1, 2'h0, 5'h18, 1'b0);
    fr(SRC_P2, 3'h5, 1'b0, 2'h0, 5'h19, 1'b1);
    chk("learn port", 32'h1, lPort);
    wr(ADR_P1CTRL, 32'h0);
    fr(SRC_P1, 3'h6, 1'b0, 2'h0, 5'h10, 1'b1);
    // Host frames in every tag code, lookup and directed
    fr(SRC_HOST, 3'h3, 1'b0, TAG_LOOKUP, 5'h14, 1'b0);
    fr(SRC_HOST, 3'h3, 1'b0, TAG_P1, 5'h12, 1'b0);
    fr(SRC_HOST, 3'h3, 1'b0, TAG_P2, 5'h14, 1'b0);
    fr(SRC_HOST, 3'h3, 1'b0, TAG_BOTH, 5'h16, 1'b0);
    wr(ADR_P1CTRL, 32'h1);
    wr(ADR_GCTRL2, GC2_SELFCLR);
    repeat (2) @(posedge core_clk);
    chk("flush dyn", 32'h1, sDyn);
    chk("flush sta", 32'h1, sSta);
    rd(ADR_GCTRL2); chk("gctrl2 clr", 32'h0, d);
    i_stg_host_model.set_busy(2'h1);
    wr(ADR_P1CTRL, 32'h6);
    rd(ADR_STATUS); chk("pending", 32'h40, d & 32'hc0);
    fr(SRC_P1, 3'h6, 1'b0, 2'h0, 5'h10, 1'b0);
    i_stg_host_model.set_busy(2'h0);
    repeat (2) @(posedge core_clk);
    fr(SRC_P1, 3'h6, 1'b0, 2'h0, 5'h1c, 1'b1);
    end_of_test();
  end

  initial begin
    #100000;
    errCount++;
    end_of_test();
  end
endmodule // stg_gate_top_tb

//--- bench/stg_host_model.sv
// Processor and port traffic model feeding the decision interface
`timescale 1ns/1ns
module stg_host_model (
  input  wire logic       core_clk,
  output logic            lkValid,
  output logic [1:0]      lkSrc,
  output logic [2:0]      lkDstMask,
  output logic            lkStaticOvr,
  output logic [1:0]      lkHostTag,
  output logic [1:0]      frameBusy,
  input  wire logic       fwdValid,
  input  wire logic [2:0] fwdMask,
  input  wire logic       fwdTailSrc,
  input  wire logic       learnValid,
  input  wire logic       learnPort
);
  logic [4:0] got;
  initial begin
    lkValid = 1'b0;
    lkSrc = 2'h3;
    lkDstMask = 3'h0;
    lkStaticOvr = 1'b0;
    lkHostTag = 2'h0;
    frameBusy = 2'h0;
  end
  // One decision; caught as valid, mask, tail bit
  // directed frames reach the tagged port even when the bench closed it
  // override flag marks protocol frames the host must see
  // version sorting stays in host software, not on this path
  task automatic send(input logic [1:0] s, input logic [2:0] m,
                      input logic o, input logic [1:0] t);
    @(posedge core_clk);
    lkValid <= 1'b1;
    lkSrc <= s;
    lkDstMask <= m;
    lkStaticOvr <= o;
    lkHostTag <= t;
    @(posedge core_clk);
    lkValid <= 1'b0;
    lkDstMask <= ~m; // Released mask and tag lines do not keep old value
    lkHostTag <= ~t;
    #1;
    got = {fwdValid, fwdMask, fwdTailSrc};
  endtask
  // Frame in progress on network ports
  task automatic set_busy(input logic [1:0] b);
    @(posedge core_clk);
    frameBusy <= b;
  endtask
endmodule // stg_host_model

//--- hw/stg_gate_top.sv
// Spanning tree port state gating with AXI4-Lite registers
// Operation
// - Port 3 is the processor port and is never gated by port state.
// - Each network port has transmit, receive and learning-disable bits.
// - With transmit and receive off, user frames are neither taken nor sent.
// - Override-bit static matches still reach the processor port.
// - Learning disable set means no source address learning on the port.
// - Learning state learns but forwards only processor traffic.
// - Forwarding state receives, forwards and learns normally.
// - Rapid discarding uses the same off, off, no-learn setting.
// - Global control 2 bits 5 and 4 flush table entries of ports with learning disable set.
// - Tail tag 00 lookup, 01 port 1, 10 port 2, 11 both; bit 0 source.
`timescale 1ns/1ns
module stg_gate_top (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  frameBusy,
  input  wire logic        lkValid,
  input  wire logic [1:0]  lkSrc,
  input  wire logic [2:0]  lkDstMask,
  input  wire logic        lkStaticOvr,
  input  wire logic [1:0]  lkHostTag,
  output logic             fwdValid,
  output logic [2:0]       fwdMask,
  output logic             fwdTailSrc,
  output logic             learnValid,
  output logic             learnPort,
  output logic [1:0]       flushDyn,
  output logic [1:0]       flushSta
);
  import stg_pkg::*;
  logic [2:0]  p1Ctl_ff, p2Ctl_ff, fwdMask_ff, nxt_fwdMask;
  logic [7:0]  gc2_ff, awAddr_ff;
  logic [1:0]  effTx, effRx, effLd, pending, bresp_ff, rresp_ff;
  logic [1:0]  flushDyn_ff, flushSta_ff;
  logic [31:0] wData_ff, rdata_ff;
  logic        awready_ff, wready_ff, bvalid_ff, awGot_ff, wGot_ff;
  logic        wStrb0_ff, arready_ff, rvalid_ff, doWrite;
  logic        fwdValid_ff, fwdTailSrc_ff, learnValid_ff, learnPort_ff;
  logic        nxt_learn, srcIdx, othIdx;
  // Address decode shared by both bus paths
  function automatic logic [2:0] regSel(input logic [7:0] a);
    case (a)
      ADR_STATUS: regSel = 3'h1;
      ADR_GCTRL2: regSel = 3'h2;
      ADR_P1CTRL: regSel = 3'h3;
      ADR_P2CTRL: regSel = 3'h4;
      default:    regSel = 3'h0;
    endcase
  endfunction

  for (genvar g = 0; g < 2; g++) begin : g_port
    stg_port_gate u_gate (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .cfgTx     (g == 0 ? p1Ctl_ff[CTL_TX_BIT] : p2Ctl_ff[CTL_TX_BIT]),
      .cfgRx     (g == 0 ? p1Ctl_ff[CTL_RX_BIT] : p2Ctl_ff[CTL_RX_BIT]),
      .cfgLd     (g == 0 ? p1Ctl_ff[CTL_LD_BIT] : p2Ctl_ff[CTL_LD_BIT]),
      .frameBusy (frameBusy[g]),
      .effTx     (effTx[g]),
      .effRx     (effRx[g]),
      .effLd     (effLd[g]),
      .pending   (pending[g])
    );
  end

  // Write channel: one write at a time, address and data in any order
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awGot_ff   <= 1'b0;
      wGot_ff    <= 1'b0;
      awAddr_ff  <= 8'h00;
      wData_ff   <= 32'h00000000;
      wStrb0_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awAddr_ff  <= s_axi_awaddr;
        awGot_ff   <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wData_ff  <= s_axi_wdata;
        wStrb0_ff <= s_axi_wstrb[0];
        wGot_ff   <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (doWrite) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (regSel(awAddr_ff) inside {3'h2, 3'h3, 3'h4}) ?
                     RESP_OKAY : RESP_SLVERR;
        awGot_ff  <= 1'b0;
        wGot_ff   <= 1'b0;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end
  assign doWrite = awGot_ff && wGot_ff && !bvalid_ff;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      p1Ctl_ff <= CTL_RST;
      p2Ctl_ff <= CTL_RST;
      gc2_ff   <= GC2_RST;
    end else if (doWrite && wStrb0_ff) begin
      if (regSel(awAddr_ff) == 3'h3) p1Ctl_ff <= wData_ff[2:0];
      if (regSel(awAddr_ff) == 3'h4) p2Ctl_ff <= wData_ff[2:0];
      if (regSel(awAddr_ff) == 3'h2) gc2_ff <= wData_ff[7:0] & ~GC2_SELFCLR;
    end
  end
  // flush pulses to ports not learning
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flushDyn_ff <= 2'b00;
      flushSta_ff <= 2'b00;
    end else begin
      flushDyn_ff <= {2{doWrite && wStrb0_ff && regSel(awAddr_ff) == 3'h2
                       && wData_ff[GC2_FLDYN_BIT]}} & effLd;
      flushSta_ff <= {2{doWrite && wStrb0_ff && regSel(awAddr_ff) == 3'h2
                       && wData_ff[GC2_FLSTA_BIT]}} & effLd;
    end
  end
  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= RESP_OKAY;
      unique case (regSel(s_axi_araddr))
        3'h1: rdata_ff <= {24'h000000, pending, effTx[1], effRx[1],
                           effLd[1], effTx[0], effRx[0], effLd[0]};
        3'h2: rdata_ff <= {24'h000000, gc2_ff};
        3'h3: rdata_ff <= {29'h00000000, p1Ctl_ff};
        3'h4: rdata_ff <= {29'h00000000, p2Ctl_ff};
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end
  assign srcIdx = (lkSrc == SRC_P2);
  assign othIdx = ~srcIdx;
  // Forwarding decision for one looked-up frame
  always_comb begin
    nxt_fwdMask = 3'b000;
    nxt_learn   = 1'b0;
    if (lkSrc == SRC_HOST) begin
      unique case (lkHostTag)
        TAG_LOOKUP: nxt_fwdMask = lkDstMask & {1'b0, effTx};
        TAG_P1:     nxt_fwdMask = 3'b001;
        TAG_P2:     nxt_fwdMask = 3'b010;
        TAG_BOTH:   nxt_fwdMask = 3'b011;
      endcase
    end else if (lkSrc == SRC_P1 || lkSrc == SRC_P2) begin
      if (effRx[srcIdx]) begin
        nxt_fwdMask = lkDstMask;
        nxt_fwdMask[othIdx] = lkDstMask[othIdx] && effTx[othIdx];
      end else if (lkStaticOvr && lkDstMask[MSK_HOST]) begin
        nxt_fwdMask = 3'b100;
      end
      nxt_fwdMask[srcIdx] = 1'b0;
      nxt_learn = !effLd[srcIdx];
    end
  end
  // Decision outputs registered one cycle after lookup
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fwdValid_ff   <= 1'b0;
      fwdMask_ff    <= 3'b000;
      fwdTailSrc_ff <= 1'b0;
      learnValid_ff <= 1'b0;
      learnPort_ff  <= 1'b0;
    end else begin
      fwdValid_ff   <= lkValid;
      fwdMask_ff    <= lkValid ? nxt_fwdMask : 3'b000;
      fwdTailSrc_ff <= lkValid && (lkSrc == SRC_P2);
      learnValid_ff <= lkValid && nxt_learn;
      learnPort_ff  <= srcIdx;
    end
  end
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign fwdValid      = fwdValid_ff;
  assign fwdMask       = fwdMask_ff;
  assign fwdTailSrc    = fwdTailSrc_ff;
  assign learnValid    = learnValid_ff;
  assign learnPort     = learnPort_ff;
  assign flushDyn      = flushDyn_ff;
  assign flushSta      = flushSta_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_blocked_user;
    lkValid && lkSrc != SRC_HOST && !effRx[srcIdx] |=> fwdMask[1:0] == 2'b00;
  endproperty
  a_blocked_user: assert property (p_blocked_user)
    else $error("user frame forwarded from a blocked port");
  property p_override_host;
    lkValid && lkSrc != SRC_HOST && !effRx[srcIdx] && lkStaticOvr
      && lkDstMask[MSK_HOST] |=> fwdValid && fwdMask == 3'b100;
  endproperty
  a_override_host: assert property (p_override_host)
    else $error("override frame did not reach processor");
  property p_no_learn;
    lkValid && lkSrc != SRC_HOST && effLd[srcIdx] |=> !learnValid;
  endproperty
  a_no_learn: assert property (p_no_learn)
    else $error("learned while learning disabled");
  property p_learn_state;
    lkValid && lkSrc == SRC_P2 && !effLd[1]
      |=> learnValid && learnPort;
  endproperty
  a_learn_state: assert property (p_learn_state)
    else $error("port 2 did not learn with learning enabled");
  property p_forward;
    lkValid && lkSrc == SRC_P1 && effRx[0] && effTx[1]
      && lkDstMask[MSK_P2] |=> fwdMask[MSK_P2];
  endproperty
  a_forward: assert property (p_forward)
    else $error("forwarding state dropped a user frame");
  property p_tag_both;
    lkValid && lkSrc == SRC_HOST && lkHostTag == TAG_BOTH
      |=> fwdMask == 3'b011;
  endproperty
  a_tag_both: assert property (p_tag_both)
    else $error("tail tag 11 did not reach both ports");
  property p_tag_p1;
    lkValid && lkSrc == SRC_HOST && lkHostTag == TAG_P1
      |=> fwdValid && fwdMask == 3'b001 && !fwdTailSrc;
  endproperty
  a_tag_p1: assert property (p_tag_p1)
    else $error("processor frame to port 1 was gated");
  // Flush mask follows the state seen at the write edge
  property p_flush;
    (flushDyn != 2'b00)
      |-> $past(doWrite) && (flushDyn & ~$past(effLd)) == 2'b00;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush without write or on a learning port");
  // New setting copied at the first idle edge after the write
  property p_ctl_steer;
    doWrite && wStrb0_ff && regSel(awAddr_ff) == 3'h3 ##1 !frameBusy[0]
      |=> effRx[0] == $past(wData_ff[CTL_RX_BIT], 2);
  endproperty
  a_ctl_steer: assert property (p_ctl_steer)
    else $error("port 1 setting not applied when idle");
endmodule // stg_gate_top

//--- hw/stg_pkg.sv
// Constants for the spanning tree port state gate
package stg_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned IDX_STATUS  = 1;
  localparam int unsigned IDX_GCTRL2  = 2;
  localparam int unsigned IDX_P1CTRL  = 18;
  localparam int unsigned IDX_P2CTRL  = 34;
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  ADR_STATUS  = 8'(IDX_STATUS * 4);
  localparam logic [7:0]  ADR_GCTRL2  = 8'(IDX_GCTRL2 * 4);
  localparam logic [7:0]  ADR_P1CTRL  = 8'(IDX_P1CTRL * 4);
  localparam logic [7:0]  ADR_P2CTRL  = 8'(IDX_P2CTRL * 4);

  // Port control fields
  localparam int unsigned CTL_TX_BIT  = 2;
  localparam int unsigned CTL_RX_BIT  = 1;
  localparam int unsigned CTL_LD_BIT  = 0;
  localparam logic [2:0]  CTL_RST     = 3'h6;

  // Global control 2 fields
  localparam int unsigned GC2_FLDYN_BIT = 5;
  localparam int unsigned GC2_FLSTA_BIT = 4;
  localparam logic [7:0]  GC2_RST       = 8'h00;
  localparam logic [7:0]  GC2_SELFCLR   = 8'h30;

  // Destination mask bits
  localparam int unsigned MSK_P1   = 0;
  localparam int unsigned MSK_P2   = 1;
  localparam int unsigned MSK_HOST = 2;

  // Ingress source codes
  localparam logic [1:0] SRC_P1   = 2'h0;
  localparam logic [1:0] SRC_P2   = 2'h1;
  localparam logic [1:0] SRC_HOST = 2'h2;

  // Tail tag destination codes from the processor
  localparam logic [1:0] TAG_LOOKUP = 2'h0;
  localparam logic [1:0] TAG_P1     = 2'h1;
  localparam logic [1:0] TAG_P2     = 2'h2;
  localparam logic [1:0] TAG_BOTH   = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- hw/stg_port_gate.sv
// Per-port state holder that applies new settings between frames
`timescale 1ns/1ns
module stg_port_gate (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic cfgTx,
  input  wire logic cfgRx,
  input  wire logic cfgLd,
  input  wire logic frameBusy,
  output logic      effTx,
  output logic      effRx,
  output logic      effLd,
  output logic      pending
);
  import stg_pkg::*;

  logic effTx_ff;
  logic effRx_ff;
  logic effLd_ff;
  logic pending_ff;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      effTx_ff <= CTL_RST[CTL_TX_BIT];
      effRx_ff <= CTL_RST[CTL_RX_BIT];
      effLd_ff <= CTL_RST[CTL_LD_BIT];
    end else if (!frameBusy) begin
      effTx_ff <= cfgTx;
      effRx_ff <= cfgRx;
      effLd_ff <= cfgLd;
    end
  end

  // Flags a setting still waiting for the frame to end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pending_ff <= 1'b0;
    end else begin
      pending_ff <= frameBusy &&
        ({cfgTx, cfgRx, cfgLd} != {effTx_ff, effRx_ff, effLd_ff});
    end
  end

  assign effTx   = effTx_ff;
  assign effRx   = effRx_ff;
  assign effLd   = effLd_ff;
  assign pending = pending_ff;

  property p_hold_in_frame;
    @(posedge core_clk) disable iff (!rstn)
    frameBusy |=> $stable({effTx_ff, effRx_ff, effLd_ff});
  endproperty
  a_hold_in_frame: assert property (p_hold_in_frame)
    else $error("port state changed inside a frame");

  property p_take_when_idle;
    @(posedge core_clk) disable iff (!rstn)
    !frameBusy |=> {effTx_ff, effRx_ff, effLd_ff} ==
                   $past({cfgTx, cfgRx, cfgLd});
  endproperty
  a_take_when_idle: assert property (p_take_when_idle)
    else $error("port state not taken between frames");

endmodule // stg_port_gate
